// File: include/cmd_decode_map.vh
// Purpose: constants for the command decoder
// Assumes: plain Verilog-2005 includes
// Notes:   command codes are internal encodings of the decoded command
`ifndef CMD_DECODE_MAP_VH
`define CMD_DECODE_MAP_VH

// decoded command codes, 5 bits
`define CMD_NONE      5'h00
`define CMD_MRS       5'h01
`define CMD_REF       5'h02
`define CMD_SRE       5'h03
`define CMD_SRX       5'h04
`define CMD_PRE       5'h05
`define CMD_PREA      5'h06
`define CMD_ACT       5'h07
`define CMD_WR        5'h08
`define CMD_WRA       5'h09
`define CMD_RD        5'h0a
`define CMD_RDA       5'h0b
`define CMD_NOP       5'h0c
`define CMD_DES       5'h0d
`define CMD_PDE       5'h0e
`define CMD_PDX       5'h0f
`define CMD_ZQCL      5'h10
`define CMD_ZQCS      5'h11
`define CMD_ILLEGAL   5'h12

// address bit positions
`define AP_BIT        10
`define BC_BIT        12

// burst lengths in beats
`define BURST_FULL    4'h8
`define BURST_CHOP    4'h4

// burst runtime: beats over two per clock (double data rate)
`define BURST_CYC_FULL 3'h4
`define BURST_CYC_CHOP 3'h2

// power state codes
`define PST_ACTIVE    2'h0
`define PST_PDOWN     2'h1
`define PST_SREF      2'h2

// reset values
`define RST_CMD       5'h00
`define RST_PST       2'h0

`endif

// File: design/in_sync.v
// Purpose: two flop synchroniser for a bundle of pin levels
// Assumes: pins are asynchronous to ref_clk
// Notes:   first stage is read only by the second stage
`timescale 1ns/1ps
module in_sync #(
   parameter WIDTH = 1,
   parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
   input  wire             ref_clk,
   input  wire             rst_n,
   input  wire [WIDTH-1:0] pin_in,
   output wire [WIDTH-1:0] pin_sync
);
   reg [WIDTH-1:0] meta_reg;   // first stage, metastability catch
   reg [WIDTH-1:0] sync_reg;   // second stage, safe to use

   // plain double flop; reset to a quiet level
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_reg <= RST_VAL;
         sync_reg <= RST_VAL;
      end else begin
         meta_reg <= pin_in;
         sync_reg <= meta_reg;
      end
   end

   assign pin_sync = sync_reg;
endmodule

// File: design/burst_tracker.v
// Purpose: tracks a read or write burst until it completes
// Assumes: start pulses come from the decoder on the same clock
// Notes:   a burst cannot be cut short by any later command
`timescale 1ns/1ps
`include "cmd_decode_map.vh"
module burst_tracker (
   input  wire       ref_clk,
   input  wire       rst_n,
   input  wire       start,
   input  wire [2:0] cycles,
   output wire       busy
);
   reg [2:0] left_reg;   // clocks remaining in burst
   reg [2:0] left_next;

   // reload only when idle; nothing else may shorten the count
   always @* begin
      left_next = left_reg;
      if (left_reg != 3'h0)
         left_next = left_reg - 3'h1;
      else if (start)
         left_next = cycles;
   end

   // count register
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n)
         left_reg <= 3'h0;
      else
         left_reg <= left_next;
   end

   assign busy = (left_reg != 3'h0);
endmodule

// File: design/ddr3_command_decoder.v
// Purpose: command decoder of a DDR3 type SDRAM
// Assumes: controller drives pins in step with ref_clk edges
// Notes:   sampled pins pass two flops, so decode lags pins by two
//          outputs are registered, so a command shows three edges
//          after the edge that launched it on the pins
//          self refresh exit is taken on the synchronised cke, not
//          on the raw pin, trading exit latency for a clean clock
//          domain crossing
//          mode inputs stand in for mode register contents and
//          are read directly, as they come from the same clock
//          a non-entry command with cke falling is reported on cmd_code
//          and leaves the power state as it was
`timescale 1ns/1ps
`include "cmd_decode_map.vh"
module ddr3_command_decoder #(
   parameter BA_W  = 3,    // bank address width
   parameter ROW_W = 16,   // row address width
   parameter COL_W = 10    // column address width
) (
   input  wire             ref_clk,
   input  wire             rst_n,
   input  wire             cke,
   input  wire             cs_n,
   input  wire             ras_n,
   input  wire             cas_n,
   input  wire             we_n,
   input  wire             odt,
   input  wire [BA_W-1:0]  ba,
   input  wire [ROW_W-1:0] addr,
   input  wire             mode_otf,
   input  wire             mode_chop,
   output reg  [4:0]       cmd_code,
   output reg              cmd_valid,
   output reg  [BA_W-1:0]  cmd_bank,
   output reg  [ROW_W-1:0] cmd_row,
   output reg  [COL_W-1:0] cmd_col,
   output reg  [15:0]      cmd_opcode,
   output reg              cmd_auto_pre,
   output reg  [3:0]       cmd_burst_len,
   output reg  [1:0]       power_state,
   output wire             odt_enable,
   output wire             refresh_allowed,
   output wire             burst_busy
);
   // synchronised pin bundle: cke, cs, ras, cas, we, odt
   // all pins travel through one synchroniser so that a command
   // is never split across two decode cycles; board skew between
   // pins is the controller's concern, not ours
   localparam PW = 6 + BA_W + ROW_W;
   wire [PW-1:0] pins_raw;   // raw pin bundle
   wire [PW-1:0] pins_s;     // after two flops

   // cs and strobes rest high so reset looks like deselect
   // odt rests low so termination stays off until requested
   localparam [PW-1:0] PIN_RST = {1'b0, 4'hf, 1'b0, {(BA_W+ROW_W){1'b0}}};

   // packing order: cke, cs, ras, cas, we, odt, bank, address
   assign pins_raw = {cke, cs_n, ras_n, cas_n, we_n, odt, ba, addr};

   // every pin is asynchronous to the decoder clock
   // the reset level holds cke low, so the first decoded cycles are none,
   // so nothing spurious leaves the decoder after reset
   in_sync #(
      .WIDTH   (PW),
      .RST_VAL (PIN_RST)
   ) u_sync (
      .ref_clk  (ref_clk),
      .rst_n    (rst_n),
      .pin_in   (pins_raw),
      .pin_sync (pins_s)
   );

   wire             cke_s;   // current cycle cke
   wire             cs_s;    // chip select, active low
   wire             ras_s;   // row strobe, active low
   wire             cas_s;   // column strobe, active low
   wire             we_s;    // write enable, active low
   wire             odt_s;   // termination control
   wire [BA_W-1:0]  ba_s;    // bank lines
   wire [ROW_W-1:0] a_s;     // address lines

   // unpack in the same order as the bundle was packed
   assign {cke_s, cs_s, ras_s, cas_s, we_s, odt_s, ba_s, a_s} = pins_s;

   reg cke_prev_reg;   // cke sampled at the prior edge

   // resets low: the first high cke after reset reads as a rising
   // edge in the active state, which decodes to no command at all;
   // the controller spends one extra edge with cke high before use
   // previous cycle cke held one edge back
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n)
         cke_prev_reg <= 1'b0;
      else
         cke_prev_reg <= cke_s;
   end

   // cke qualifiers and the idle patterns
   wire cke_hh;   // cke high in both cycles
   wire cke_hl;   // cke falling
   wire cke_lh;   // cke rising
   wire is_des;   // deselect: cs high
   wire is_nop;   // nop encoding
   wire is_idle;  // nop or deselect

   // the two cke samples select ordinary decode, entry commands
   // (falling) or exit commands (rising); low in both cycles
   // holds whatever low power state is current
   assign cke_hh = cke_prev_reg & cke_s;
   assign cke_hl = cke_prev_reg & ~cke_s;
   assign cke_lh = ~cke_prev_reg & cke_s;
   // cs high masks the strobes and address; cke and odt still act
   assign is_des  = cs_s;
   assign is_nop  = ~cs_s & ras_s & cas_s & we_s;
   assign is_idle = is_des | is_nop;

   // burst length chosen from mode or a12 on the fly
   // on the fly selection reads a12 per command; otherwise the
   // fixed mode input decides and a12 plays no part in length
   // burst clocks are beats over two, data moving on both edges
   wire       bc_bit;      // a12 level
   wire       chop;        // burst is chopped to four
   wire [3:0] blen;        // burst beats
   wire [2:0] bcyc;        // burst clocks

   assign bc_bit = a_s[`BC_BIT];
   assign chop   = mode_otf ? ~bc_bit : mode_chop;
   assign blen   = chop ? `BURST_CHOP : `BURST_FULL;
   assign bcyc   = chop ? `BURST_CYC_CHOP : `BURST_CYC_FULL;

   // state and decode holders
   // code_next is the decode of the current synchronised cycle
   reg [1:0] pst_reg;    // power state
   reg [1:0] pst_next;
   reg [4:0] code_next;  // decoded command

   // classify the sampled pins
   // decode order: power state first, then the cke pair, then
   // the strobes; a low power state ignores every strobe pattern
   // except nop or deselect with cke rising, so stray levels on
   // floating pins there cannot start an operation
   // cke falling with anything but refresh, nop or deselect is
   // flagged illegal rather than silently dropped
   always @* begin
      code_next = `CMD_NONE;
      case (pst_reg)
         `PST_SREF: begin
            // only cke rising with nop/deselect leaves self refresh
            // anything else keeps the device in self refresh
            if (cke_lh && is_idle)
               code_next = `CMD_SRX;
         end
         `PST_PDOWN: begin
            // nop or deselect with cke rising is the only way out
            if (cke_lh && is_idle)
               code_next = `CMD_PDX;
         end
         default: begin
            // active: full decode while cke stays high
            if (cke_hl) begin
               // falling cke: entry commands only
               if (!cs_s && !ras_s && !cas_s && we_s)
                  code_next = `CMD_SRE;
               else if (is_idle)
                  code_next = `CMD_PDE;
               else
                  // not an entry command: report it
                  code_next = `CMD_ILLEGAL;
            end else if (cke_hh) begin
               // deselect masks the strobes, so test it first
               if (is_des)
                  code_next = `CMD_DES;
               else begin
                  // odt plays no part in the decode
                  // strobes as {ras, cas, we}, all active low
                  case ({ras_s, cas_s, we_s})
                     3'b000: code_next = `CMD_MRS;
                     3'b001: code_next = `CMD_REF;
                     3'b010: begin
                        if (a_s[`AP_BIT])
                           code_next = `CMD_PREA;
                        else
                           code_next = `CMD_PRE;
                     end
                     3'b011: code_next = `CMD_ACT;
                     3'b100: begin
                        if (a_s[`AP_BIT])
                           code_next = `CMD_WRA;
                        else
                           code_next = `CMD_WR;
                     end
                     3'b101: begin
                        if (a_s[`AP_BIT])
                           code_next = `CMD_RDA;
                        else
                           code_next = `CMD_RD;
                     end
                     3'b110: begin
                        if (a_s[`AP_BIT])
                           code_next = `CMD_ZQCL;
                        else
                           code_next = `CMD_ZQCS;
                     end
                     default: code_next = `CMD_NOP;
                  endcase
               end
            end
         end
      endcase
   end

   // power state follows entry and exit commands
   // entry and exit are the only moves; every other code keeps
   // the current state, so illegal codes cannot strand it
   always @* begin
      pst_next = pst_reg;
      case (code_next)
         `CMD_SRE: pst_next = `PST_SREF;
         `CMD_PDE: pst_next = `PST_PDOWN;
         `CMD_SRX: pst_next = `PST_ACTIVE;
         `CMD_PDX: pst_next = `PST_ACTIVE;
         default:  pst_next = pst_reg;
      endcase
   end

   // power state register; reset only through rst_n
   // the port power_state is a registered twin of this state,
   // kept apart so internal use never loads the output flop
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n)
         pst_reg <= `RST_PST;
      else
         pst_reg <= pst_next;
   end

   // every read or write variant starts a burst; auto precharge
   // and length are attributes carried on the outputs
   // a start while a burst runs is ignored by the tracker, which
   // keeps an earlier burst from being cut short
   wire is_rw;       // read or write decoded
   wire burst_go;    // start of a burst

   assign is_rw = (code_next == `CMD_WR) || (code_next == `CMD_WRA) ||
                  (code_next == `CMD_RD) || (code_next == `CMD_RDA);
   assign burst_go = is_rw;

   // bursts are never cut; nop passes through untouched
   // nop and deselect never reach the tracker, so they cannot
   // disturb a burst in flight
   burst_tracker u_burst (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .start   (burst_go),
      .cycles  (bcyc),
      .busy    (burst_busy)
   );

   // registered command outputs, one cycle per decoded command
   // cmd_valid stands for one cycle per command; the address
   // fields hold their value until the next command that uses
   // them, so a consumer may read them late
   // cmd_auto_pre clears on every cycle that is not a read or
   // write, so a stale flag never rides on a later command
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cmd_code      <= `RST_CMD;
         cmd_valid     <= 1'b0;
         cmd_bank      <= {BA_W{1'b0}};
         cmd_row       <= {ROW_W{1'b0}};
         cmd_col       <= {COL_W{1'b0}};
         cmd_opcode    <= 16'h0000;
         cmd_auto_pre  <= 1'b0;
         cmd_burst_len <= 4'h0;
         power_state   <= `RST_PST;
      end else begin
         cmd_code    <= code_next;
         // nop, deselect and none do not count as commands
         cmd_valid   <= (code_next != `CMD_NONE) &&
                        (code_next != `CMD_NOP) &&
                        (code_next != `CMD_DES);
         power_state <= pst_next;
         cmd_auto_pre <= 1'b0;
         // address fields captured only for commands that use them
         case (code_next)
            `CMD_MRS: begin
               cmd_bank   <= ba_s;
               cmd_opcode <= {{(16-ROW_W){1'b0}}, a_s};
            end
            `CMD_ACT: begin
               cmd_bank <= ba_s;
               cmd_row  <= a_s;
            end
            `CMD_PRE: begin
               cmd_bank <= ba_s;
            end
            `CMD_WR, `CMD_WRA, `CMD_RD, `CMD_RDA: begin
               cmd_bank      <= ba_s;
               cmd_col       <= a_s[COL_W-1:0];
               cmd_auto_pre  <= a_s[`AP_BIT];
               cmd_burst_len <= blen;
            end
            default: begin
               // other codes leave the fields alone
               cmd_bank <= cmd_bank;
            end
         endcase
      end
   end

   // termination off in self refresh and in reset
   // odt passes only outside self refresh; the decode above never
   // looks at it, so it cannot alter any command
   assign odt_enable = odt_s & (pst_reg != `PST_SREF);

   // no refresh while powered down
   // no refresh runs in power down or self refresh; scheduling
   // around them is the controller's job
   assign refresh_allowed = (pst_reg == `PST_ACTIVE);
endmodule

// File: testbench/ctl_model.sv
// Purpose: memory controller model driving the command pins
// Assumes: a command is launched just after a rising edge
// Notes:   each command is followed by a nop at the same cke
`timescale 1ns/1ps
module ctl_model (
   input  wire         ref_clk,
   output logic        cke,
   output logic        cs_n,
   output logic        ras_n,
   output logic        cas_n,
   output logic        we_n,
   output logic        odt,
   output logic [2:0]  ba,
   output logic [15:0] addr   // only configured bits exist
);
   // power up with cke low and the device deselected
   initial begin
      {cke, cs_n, ras_n, cas_n, we_n, odt} = 6'h1e;
      ba = 3'h0;
      addr = 16'h0;
   end

   // one command edge, then nop with cke held
   task send(input k, c, r, a, w, input [2:0] b, input [15:0] d);
      @(posedge ref_clk);
      {cke, cs_n, ras_n, cas_n, we_n} <= {k, c, r, a, w};
      // deselected: lines float, so show them moving
      ba <= c ? ~ba : b;
      addr <= c ? ~addr : d;
      @(posedge ref_clk);
      {cs_n, ras_n, cas_n, we_n} <= 4'h7;
   endtask

   // termination request level
   task odt_on(input v);
      @(posedge ref_clk);
      odt <= v;
   endtask
endmodule

// File: testbench/ddr3_decoder_asserts.sv
// Purpose: port level checks of the command decoder
// Assumes: pins show on outputs three sampling edges later
// Notes:   needs a controller that leaves power down with nop
`timescale 1ns/1ps
`include "cmd_decode_map.vh"
module ddr3_decoder_asserts #(
   parameter BA_W  = 3,
   parameter ROW_W = 16
) (
   input wire             ref_clk,
   input wire             rst_n,
   input wire             cke,
   input wire             cs_n,
   input wire             ras_n,
   input wire             cas_n,
   input wire             we_n,
   input wire [BA_W-1:0]  ba,
   input wire [ROW_W-1:0] addr,
   input wire             mode_otf,
   input wire             mode_chop,
   input wire [4:0]       cmd_code,
   input wire             cmd_valid,
   input wire [BA_W-1:0]  cmd_bank,
   input wire             cmd_auto_pre,
   input wire [3:0]       cmd_burst_len,
   input wire [1:0]       power_state,
   input wire             odt_enable,
   input wire             burst_busy
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   // pin groups at the sampling edge
   wire nop_des = cs_n | (ras_n & cas_n & we_n);
   wire rw      = !cs_n & ras_n & !cas_n;
   wire is_ref  = !cs_n & !ras_n & !cas_n & we_n;
   wire is_bst  = cmd_code >= `CMD_WR && cmd_code <= `CMD_RDA;

   // code expected when cke stayed high
   function [4:0] dec(input [3:0] p, input ap);
      case (p)
         4'h0: dec = `CMD_MRS;
         4'h1: dec = `CMD_REF;
         4'h2: dec = ap ? `CMD_PREA : `CMD_PRE;
         4'h3: dec = `CMD_ACT;
         4'h4: dec = ap ? `CMD_WRA : `CMD_WR;
         4'h5: dec = ap ? `CMD_RDA : `CMD_RD;
         4'h6: dec = ap ? `CMD_ZQCL : `CMD_ZQCS;
         default: dec = `CMD_NONE;
      endcase
   endfunction

   // cke high, or just fallen, over four edges
   sequence s_up;
      cke && $past(cke) && $past(cke, 2) && $past(cke, 3);
   endsequence
   sequence s_dn;
      !cke && $past(cke) && $past(cke, 2) && $past(cke, 3);
   endsequence
   sequence s_run8;
      burst_busy [*4] ##1 !burst_busy;
   endsequence
   sequence s_run4;
      burst_busy [*2] ##1 !burst_busy;
   endsequence

   property p_decode;
      s_up ##0 !nop_des |-> ##3 cmd_valid && cmd_code ==
         dec($past({cs_n, ras_n, cas_n, we_n}, 3), $past(addr[10], 3));
   endproperty
   property p_fields;
      s_up ##0 rw |-> ##3 cmd_bank == $past(ba, 3) &&
         cmd_auto_pre == $past(addr[10], 3);
   endproperty
   property p_len;
      s_up ##0 rw |-> ##3 cmd_burst_len == (mode_otf ?
         ($past(addr[12], 3) ? 4'h8 : 4'h4) : (mode_chop ? 4'h4 : 4'h8));
   endproperty
   property p_nop;
      s_up ##0 nop_des |-> ##3 !cmd_valid;
   endproperty
   // busy rises on the same edge as the command output
   property p_busy8;
      cmd_valid && is_bst && cmd_burst_len == 4'h8 |-> s_run8;
   endproperty
   property p_busy4;
      cmd_valid && is_bst && cmd_burst_len == 4'h4 |-> s_run4;
   endproperty
   property p_sre;
      s_dn ##0 is_ref |-> ##3 cmd_code == `CMD_SRE
         ##[0:1] power_state == `PST_SREF;
   endproperty
   property p_pde;
      s_dn ##0 nop_des |-> ##3 cmd_code == `CMD_PDE
         ##[0:1] power_state == `PST_PDOWN;
   endproperty
   property p_srx;
      power_state == `PST_SREF && cke && !$past(cke) && nop_des
         |-> ##3 cmd_code == `CMD_SRX;
   endproperty
   property p_odt;
      power_state == `PST_SREF |-> !odt_enable;
   endproperty

   a_decode: assert property (p_decode)
      else $error("decoded code wrong");
   a_fields: assert property (p_fields)
      else $error("bank or auto precharge wrong");
   a_len: assert property (p_len)
      else $error("burst length wrong");
   a_nop: assert property (p_nop)
      else $error("nop or deselect raised valid");
   a_busy8: assert property (p_busy8)
      else $error("eight beat burst time wrong");
   a_busy4: assert property (p_busy4)
      else $error("four beat burst time wrong");
   a_sre: assert property (p_sre)
      else $error("self refresh entry missed");
   a_pde: assert property (p_pde)
      else $error("power down entry missed");
   a_srx: assert property (p_srx)
      else $error("self refresh exit missed");
   a_odt: assert property (p_odt)
      else $error("termination on in self refresh");
endmodule

bind ddr3_command_decoder ddr3_decoder_asserts #(
   .BA_W(BA_W), .ROW_W(ROW_W)) u_chk (
   .ref_clk(ref_clk), .rst_n(rst_n), .cke(cke), .cs_n(cs_n),
   .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr),
   .mode_otf(mode_otf), .mode_chop(mode_chop), .cmd_code(cmd_code),
   .cmd_valid(cmd_valid), .cmd_bank(cmd_bank),
   .cmd_auto_pre(cmd_auto_pre), .cmd_burst_len(cmd_burst_len),
   .power_state(power_state), .odt_enable(odt_enable),
   .burst_busy(burst_busy));

// File: testbench/test_ddr3_command_decoder.sv
// Purpose: self checking bench for the command decoder
// Assumes: results show three edges after the pin edge
// Notes:   mode inputs held still while a command decodes
`timescale 1ns/1ps
`include "cmd_decode_map.vh"
module test_ddr3_command_decoder;
   logic       ref_clk = 1'b0;   // 250 MHz
   logic       rst_n = 1'b0;     // async, active low
   logic       mode_otf = 1'b0;  // burst length from a12
   logic       mode_chop = 1'b0; // fixed length choice
   wire        cke, cs_n, ras_n, cas_n, we_n, odt;
   wire [2:0]  ba, cmd_bank;
   wire [15:0] addr, cmd_row, cmd_opcode;
   wire [9:0]  cmd_col;
   wire [4:0]  cmd_code;
   wire [3:0]  cmd_burst_len;
   wire [1:0]  power_state;
   wire        cmd_valid, cmd_auto_pre, odt_enable;
   wire        refresh_allowed, burst_busy;
   int         err_count = 0;
   int         compares = 0;
   // row group pins {ras, cas, we, a10} and their codes
   logic [3:0] rpin [7] = '{4'h0, 4'h2, 4'h4, 4'h5, 4'h6, 4'hc, 4'hd};
   logic [4:0] rexp [7] = '{`CMD_MRS, `CMD_REF, `CMD_PRE, `CMD_PREA,
                            `CMD_ACT, `CMD_ZQCS, `CMD_ZQCL};

   // 4 ns period
   always #2 ref_clk = ~ref_clk;

   ctl_model u_ctl (.ref_clk(ref_clk), .cke(cke), .cs_n(cs_n),
      .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .odt(odt), .ba(ba),
      .addr(addr));

   ddr3_command_decoder uut (.ref_clk(ref_clk), .rst_n(rst_n),
      .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
      .odt(odt), .ba(ba), .addr(addr), .mode_otf(mode_otf),
      .mode_chop(mode_chop), .cmd_code(cmd_code), .cmd_valid(cmd_valid),
      .cmd_bank(cmd_bank), .cmd_row(cmd_row), .cmd_col(cmd_col),
      .cmd_opcode(cmd_opcode), .cmd_auto_pre(cmd_auto_pre),
      .cmd_burst_len(cmd_burst_len), .power_state(power_state),
      .odt_enable(odt_enable), .refresh_allowed(refresh_allowed),
      .burst_busy(burst_busy));

   // verdict, reached from the tests and the watchdog
   task end_sim;
      $display("mismatches %0d compares %0d", err_count, compares);
      if (err_count == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // four state compare
   task chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // wait edges, then let their updates land
   task step(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   // cke up with nops, so the next command sees cke high
   task wake;
      u_ctl.send(1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 3'h0, 16'h0);
      step(4);
   endtask

   // mode set, refresh, precharge, activate and calibration
   task t_rowcmds;
      logic [15:0] a;
      for (int i = 0; i < 7; i++) begin
         a = {5'h15, rpin[i][0], 10'h2a5};
         u_ctl.send(1'b1, 1'b0, rpin[i][3], rpin[i][2], rpin[i][1],
                    i[2:0], a);
         step(2);
         chk(16'(cmd_valid), 16'h1);
         chk(16'(cmd_code), 16'(rexp[i]));
         if (i == 0)
            chk(cmd_opcode, a);
         if (i == 4)
            chk(cmd_row, a);
         if (!i[0] && i < 6)
            chk(16'(cmd_bank), 16'(i));
      end
   endtask

   // every mode and a12/a10 mix, deselect with junk just after
   task t_bursts;
      logic [3:0] len;
      logic [4:0] code;
      int         n;
      for (int i = 0; i < 32; i++) begin
         // i holds {otf, chop, a12, a10, read}
         @(posedge ref_clk);
         mode_otf <= i[4];
         mode_chop <= i[3];
         len = i[4] ? (i[2] ? 4'h8 : 4'h4) : (i[3] ? 4'h4 : 4'h8);
         code = i[0] ? (i[1] ? `CMD_RDA : `CMD_RD)
                     : (i[1] ? `CMD_WRA : `CMD_WR);
         u_ctl.send(1'b1, 1'b0, 1'b1, 1'b0, i[0], i[2:0],
                    {3'h0, i[2], 1'b0, i[1], 10'h300 | 10'(i)});
         u_ctl.send(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 3'h0, 16'h0);
         // the command stands between the third and fourth edge
         step(0);
         chk(16'(cmd_code), 16'(code));
         chk(16'(cmd_burst_len), 16'(len));
         chk(16'(cmd_auto_pre), 16'(i[1]));
         chk(16'(cmd_col), 16'h300 | 16'(i));
         n = 0;
         // busy rises with the command; the deselect shows two later
         repeat (2) begin
            if (burst_busy === 1'b1)
               n++;
            step(1);
         end
         chk(16'(cmd_code), 16'(`CMD_DES));
         chk(16'(cmd_valid), 16'h0);
         while (burst_busy === 1'b1 && n < 12) begin
            n++;
            step(1);
         end
         chk(16'(n), 16'(len >> 1));
      end
   endtask

   // power down in and out; refresh pins ignored meanwhile
   task t_power;
      u_ctl.send(1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 3'h0, 16'h0);
      step(2);
      chk(16'(cmd_code), 16'(`CMD_PDE));
      step(1);
      chk(16'(power_state), 16'(`PST_PDOWN));
      chk(16'(refresh_allowed), 16'h0);
      u_ctl.send(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 3'h0, 16'h0);
      step(3);
      chk(16'(cmd_valid), 16'h0);
      u_ctl.send(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 3'h0, 16'h0);
      step(2);
      chk(16'(cmd_code), 16'(`CMD_PDX));
      step(1);
      chk(16'(refresh_allowed), 16'h1);
   endtask

   // self refresh from idle banks, termination requested
   task t_sref;
      u_ctl.odt_on(1'b1);
      u_ctl.send(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 3'h0, 16'h0);
      step(2);
      chk(16'(cmd_code), 16'(`CMD_SRE));
      step(1);
      chk(16'(power_state), 16'(`PST_SREF));
      chk(16'(odt_enable), 16'h0);
      u_ctl.send(1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 3'h0, 16'h0);
      step(2);
      chk(16'(cmd_code), 16'(`CMD_SRX));
      step(1);
      chk(16'(odt_enable), 16'h1);
   endtask

   // reset mid run clears state before any further edge
   task t_reset;
      // cke falling with a write is no entry command
      u_ctl.send(1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 3'h0, 16'h0);
      step(2);
      chk(16'(cmd_code), 16'(`CMD_ILLEGAL));
      chk(16'(power_state), 16'(`PST_ACTIVE));
      wake;
      u_ctl.send(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 3'h0, 16'h0);
      step(5);
      @(posedge ref_clk);
      rst_n <= 1'b0;
      #1;
      chk(16'(power_state), 16'h0);
      repeat (3) @(posedge ref_clk);
      rst_n <= 1'b1;
      wake;
      t_rowcmds;
   endtask

   // main sequence
   initial begin
      repeat (3) @(posedge ref_clk);
      rst_n <= 1'b1;
      wake;
      t_rowcmds;
      t_bursts;
      t_power;
      wake;
      t_sref;
      wake;
      t_reset;
      end_sim;
   end

   // watchdog, far beyond the few hundred cycles needed
   initial begin
      #40000;
      err_count++;
      end_sim;
   end
endmodule
